/* File: logic/idr_responder.sv */
// Identify device responder with task-file registers on Wishbone
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "idr_defs.svh"

module idr_responder #(
  parameter logic DEV_ID = 1'b0,
  parameter int BUF_KB = 65536,
  parameter logic [159:0] SERIAL = {20{8'h20}},
  parameter logic [63:0] FIRMWARE = {8{8'h20}},
  parameter logic [319:0] MODEL = {40{8'h20}}
) (
  input wire logic I_CORE_CLK, // Core clock, 100 MHz
  input wire logic I_ARST_N, // Asynchronous reset, active low
  input wire logic I_WB_CYC, // Bus cycle
  input wire logic I_WB_STB, // Strobe
  input wire logic I_WB_WE, // Write enable
  input wire logic [7:0] I_WB_ADR, // Byte address
  input wire logic [31:0] I_WB_DAT, // Write data
  input wire logic [3:0] I_WB_SEL, // Byte lanes
  output logic [31:0] O_WB_DAT, // Read data
  output logic O_WB_ACK, // Acknowledge
  output logic O_IRQ // Interrupt level
);

  idr_pkg::idr_state_e state_r;
  idr_pkg::idr_state_e state_nxt;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [7:0] devhead_r;
  logic [7:0] error_r;
  logic [7:0] error_nxt;
  logic err_flag_r;
  logic err_flag_nxt;
  logic [8:0] idx_r;
  logic [8:0] idx_nxt;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_stat_nxt;
  logic [2:0] irq_mask_r;
  logic [31:0] geom_r;
  logic [31:0] opts_r;

  // One access per strobe; ack comes one cycle after the request
  wire acc = I_WB_CYC & I_WB_STB & ~ack_r;
  wire wr = acc & I_WB_WE;
  wire rd = acc & ~I_WB_WE;
  wire [31:0] lane = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                      {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

  // Address decode
  wire hit_data = I_WB_ADR == `IDR_A_DATA;
  wire hit_err = I_WB_ADR == `IDR_A_ERROR;
  wire hit_dh = I_WB_ADR == `IDR_A_DEVHEAD;
  wire hit_cmd = I_WB_ADR == `IDR_A_COMMAND;
  wire hit_st = I_WB_ADR == `IDR_A_STATUS;
  wire hit_is = I_WB_ADR == `IDR_A_IRQ_STAT;
  wire hit_im = I_WB_ADR == `IDR_A_IRQ_MASK;
  wire hit_geo = I_WB_ADR == `IDR_A_GEOM;
  wire hit_opt = I_WB_ADR == `IDR_A_OPTS;

  wire xfer = state_r == idr_pkg::IDR_XFER;

  // Command strobe; the device/head value comes from the register the host
  // wrote beforehand, not from the command write itself, as on a real task file
  wire cmd_wr = wr & hit_cmd & I_WB_SEL[0];
  wire dh_ok = devhead_r[`IDR_DH_ONE7] & devhead_r[`IDR_DH_ONE5];
  wire selected = devhead_r[`IDR_DH_DEV] == DEV_ID;
  wire is_ident = I_WB_DAT[7:0] == `IDR_CMD_IDENTIFY;
  wire start = cmd_wr & selected & is_ident & dh_ok;
  wire reject = cmd_wr & selected & ~(is_ident & dh_ok);

  // A data read during the transfer pops the next word
  wire pop = rd & hit_data & xfer;
  wire last = idx_r == 9'(`IDR_WORDS - 1);
  wire done = pop & last;

  // Buffer size word; 64MB does not fit 16 bits and reads zero
  localparam logic [15:0] BUF_WORD =
    (BUF_KB == 65536) ? 16'h0000 : 16'(BUF_KB * 2);

  // Identify word lookup by index
  function automatic idr_pkg::idr_word_t id_word(
    input logic [7:0] w,
    input logic [31:0] geom,
    input logic [31:0] opts
  );
    idr_pkg::idr_word_t v;
    int k;
    v = 16'h0000;
    k = 0;
    if (w == 8'd0) begin
      v = opts[`IDR_OPT_W0_ALT] ? `IDR_W0_B : `IDR_W0_A;
    end else if (w == 8'd1) begin
      v = geom[15:0];
    end else if (w == 8'd2) begin
      unique case (opts[`IDR_OPT_SPIN_LO +: 2])
        2'd0: v = `IDR_W2_NEED_INC;
        2'd1: v = `IDR_W2_NEED_CMP;
        2'd2: v = `IDR_W2_FREE_INC;
        2'd3: v = `IDR_W2_FREE_CMP;
      endcase
    end else if (w == 8'd3) begin
      v = {8'h00, geom[23:16]};
    end else if (w == 8'd6) begin
      v = `IDR_W6_SPT;
    end else if (w >= 8'd10 && w <= 8'd19) begin
      k = int'(w) - 10;
      v = SERIAL[159 - 16 * k -: 16];
    end else if (w == 8'd21) begin
      v = BUF_WORD;
    end else if (w >= 8'd23 && w <= 8'd26) begin
      k = int'(w) - 23;
      v = FIRMWARE[63 - 16 * k -: 16];
    end else if (w >= 8'd27 && w <= 8'd46) begin
      k = int'(w) - 27;
      v = MODEL[319 - 16 * k -: 16];
    end else if (w == 8'd47) begin
      v = {`IDR_W47_HI, geom[31:24]};
    end else if (w == 8'd48) begin
      v = `IDR_W48_BASE | {15'h0000, opts[`IDR_OPT_SECURE]};
    end
    return v;
  endfunction : id_word

  wire [15:0] cur_word = id_word(idx_r[7:0], geom_r, opts_r);

  // Status: never busy, faulted or corrected; DRQ while words remain
  wire [7:0] status;
  assign status[`IDR_ST_BSY] = 1'b0;
  assign status[`IDR_ST_RDY] = 1'b1;
  assign status[`IDR_ST_DF] = 1'b0;
  assign status[`IDR_ST_DSC] = 1'b1;
  assign status[`IDR_ST_DRQ] = xfer;
  assign status[`IDR_ST_COR] = 1'b0;
  assign status[1] = 1'b0;
  assign status[`IDR_ST_ERR] = err_flag_r;

  // Events that set sticky interrupt bits
  wire [2:0] ev_set;
  assign ev_set[`IDR_EV_DRQ] = start;
  assign ev_set[`IDR_EV_DONE] = done;
  assign ev_set[`IDR_EV_ABORT] = reject;
  wire [2:0] ev_clr = (wr & hit_is & I_WB_SEL[0]) ? I_WB_DAT[2:0] : 3'b000;

  // Sequencer and completion flags
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    error_nxt = error_r;
    err_flag_nxt = err_flag_r;
    if (start) begin
      // A new command always restarts from word zero
      state_nxt = idr_pkg::IDR_XFER;
      idx_nxt = 9'd0;
      error_nxt = 8'h00;
      err_flag_nxt = 1'b0;
    end else if (reject) begin
      state_nxt = idr_pkg::IDR_IDLE;
      idx_nxt = 9'd0;
      error_nxt = 8'h00;
      error_nxt[`IDR_ERR_ABT] = 1'b1;
      err_flag_nxt = 1'b1;
    end else if (done) begin
      state_nxt = idr_pkg::IDR_IDLE;
      idx_nxt = 9'd0;
    end else if (pop) begin
      idx_nxt = idx_r + 9'd1;
    end
  end

  // Set wins over a clear arriving in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~ev_clr) | ev_set;

  // Read mux; unmapped addresses read zero and are still acknowledged
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    if (hit_data) begin
      rdat_nxt = xfer ? {16'h0000, cur_word} : 32'h0000_0000;
    end else if (hit_err) begin
      rdat_nxt = {24'h000000, error_r};
    end else if (hit_dh) begin
      rdat_nxt = {24'h000000, devhead_r};
    end else if (hit_st) begin
      rdat_nxt = {24'h000000, status};
    end else if (hit_is) begin
      rdat_nxt = {29'h0, irq_stat_r};
    end else if (hit_im) begin
      rdat_nxt = {29'h0, irq_mask_r};
    end else if (hit_geo) begin
      rdat_nxt = geom_r;
    end else if (hit_opt) begin
      rdat_nxt = {28'h0, opts_r[3:0]};
    end
  end

  // Bus handshake and read data
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= acc;
      if (rd) begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      devhead_r <= 8'ha0;
      irq_mask_r <= 3'b000;
      geom_r <= `IDR_RST_GEOM;
      opts_r <= `IDR_RST_OPTS;
    end else begin
      if (wr & hit_dh & I_WB_SEL[0]) begin
        devhead_r <= I_WB_DAT[7:0];
      end
      if (wr & hit_im & I_WB_SEL[0]) begin
        irq_mask_r <= I_WB_DAT[2:0];
      end
      if (wr & hit_geo) begin
        geom_r <= (geom_r & ~lane) | (I_WB_DAT & lane);
      end
      if (wr & hit_opt & I_WB_SEL[0]) begin
        opts_r <= {28'h0, I_WB_DAT[3:0]};
      end
    end
  end

  // Hardware state
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= idr_pkg::IDR_IDLE;
      idx_r <= 9'd0;
      error_r <= 8'h00;
      err_flag_r <= 1'b0;
      irq_stat_r <= 3'b000;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      error_r <= error_nxt;
      err_flag_r <= err_flag_nxt;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  assign O_WB_ACK = ack_r;
  assign O_WB_DAT = rdat_r;
  assign O_IRQ = |(irq_stat_r & irq_mask_r);

endmodule : idr_responder
`default_nettype wire

/* File: logic/idr_defs.svh */
// Offsets, field positions, reset values and codes of the identify responder
`ifndef IDR_DEFS_SVH
`define IDR_DEFS_SVH
`define IDR_A_DATA 8'h00
`define IDR_A_ERROR 8'h04
`define IDR_A_DEVHEAD 8'h08
`define IDR_A_COMMAND 8'h0c
`define IDR_A_STATUS 8'h10
`define IDR_A_IRQ_STAT 8'h14
`define IDR_A_IRQ_MASK 8'h18
`define IDR_A_GEOM 8'h1c
`define IDR_A_OPTS 8'h20
`define IDR_CMD_IDENTIFY 8'hec
`define IDR_DH_ONE7 7
`define IDR_DH_ONE5 5
`define IDR_DH_DEV 4
`define IDR_ERR_ABT 2
`define IDR_ST_BSY 7
`define IDR_ST_RDY 6
`define IDR_ST_DF 5
`define IDR_ST_DSC 4
`define IDR_ST_DRQ 3
`define IDR_ST_COR 2
`define IDR_ST_ERR 0
`define IDR_EV_DRQ 0
`define IDR_EV_DONE 1
`define IDR_EV_ABORT 2
`define IDR_OPT_W0_ALT 0
`define IDR_OPT_SPIN_LO 1
`define IDR_OPT_SECURE 3
`define IDR_W0_A 16'h045a
`define IDR_W0_B 16'h045e
`define IDR_W2_NEED_INC 16'h37c8
`define IDR_W2_NEED_CMP 16'h738c
`define IDR_W2_FREE_INC 16'h8c73
`define IDR_W2_FREE_CMP 16'hc837
`define IDR_W6_SPT 16'h003f
`define IDR_W47_HI 8'h80
`define IDR_W48_BASE 16'h4000
`define IDR_WORDS 256
`define IDR_RST_GEOM 32'h1010_3fff
`define IDR_RST_OPTS 32'h0000_0006
`endif

/* File: logic/idr_pkg.sv */
// Types shared by the identify responder
`default_nettype none
package idr_pkg;
  typedef enum logic [1:0] {
    IDR_IDLE = 2'b01,
    IDR_XFER = 2'b10
  } idr_state_e;
  typedef logic [15:0] idr_word_t;
endpackage : idr_pkg
`default_nettype wire

/* File: sim/idr_responder_asserts.sv */
// Port checker for the identify responder
`timescale 1ns/1ps
`default_nettype none
module idr_responder_asserts (
  input wire logic I_CORE_CLK, // Clock
  input wire logic I_ARST_N, // Reset
  input wire logic I_WB_CYC, // Cycle
  input wire logic I_WB_STB, // Strobe
  input wire logic I_WB_WE, // Write
  input wire logic [7:0] I_WB_ADR, // Address
  input wire logic [31:0] O_WB_DAT, // Read data
  input wire logic O_WB_ACK // Ack
);
  logic [8:0] idx_r;
  wire rd = O_WB_ACK & !I_WB_WE;
  wire wd = rd && I_WB_ADR == 8'h00;
  wire [15:0] d = O_WB_DAT[15:0];
  // Word index follows the pops; any command write restarts it
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) idx_r <= 9'h000;
    else if (O_WB_ACK && I_WB_WE && I_WB_ADR == 8'h0c) idx_r <= 9'h000;
    else if (wd) idx_r <= idx_r + 9'h001;
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_req; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
  sequence s_pulse; O_WB_ACK ##1 !O_WB_ACK; endsequence
  property p_ack; s_req |=> s_pulse; endproperty
  a_ack: assert property (p_ack) else $error("ack not a pulse");
  property p_err; rd && I_WB_ADR == 8'h04 |-> (O_WB_DAT & ~32'h4) == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error bits");
  property p_stat; rd && I_WB_ADR == 8'h10 |-> !O_WB_DAT[7] && !O_WB_DAT[5] && !O_WB_DAT[2]; endproperty
  a_stat: assert property (p_stat) else $error("status bits");
  property p_w0; wd && idx_r == 9'h000 |-> d inside {16'h045a, 16'h045e}; endproperty
  a_w0: assert property (p_w0) else $error("word 0");
  property p_w2; wd && idx_r == 9'h002 |-> d inside {16'h37c8, 16'h738c, 16'h8c73, 16'hc837}; endproperty
  a_w2: assert property (p_w2) else $error("word 2");
  property p_w6; wd && idx_r == 9'h006 |-> d == 16'h003f; endproperty
  a_w6: assert property (p_w6) else $error("word 6");
  property p_w48; wd && idx_r == 9'h030 |-> d[15:1] == 15'h2000; endproperty
  a_w48: assert property (p_w48) else $error("word 48");
  property p_hi; wd |-> O_WB_DAT[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper half");
endmodule : idr_responder_asserts
bind idr_responder idr_responder_asserts idr_responder_asserts_inst (.I_CORE_CLK, .I_ARST_N,
  .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .O_WB_DAT, .O_WB_ACK);
`default_nettype wire

/* File: sim/idr_host.sv */
// Host controller model on the Wishbone side
`timescale 1ns/1ps
`default_nettype none
module idr_host (
  input wire logic i_clk, // Clock
  input wire logic i_ack, // Acknowledge
  output logic o_req, // Cycle and strobe
  output logic o_we, // Write
  output logic [7:0] o_adr, // Address
  output logic [31:0] o_dat // Write data
);
  initial begin
    {o_req, o_we, o_adr, o_dat} = '0;
  end
  // Held until ack is sampled; on release the write data is inverted, address and write enable keep their values
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_we <= we;
    o_adr <= adr;
    o_dat <= dat;
    do @(posedge i_clk); while (i_ack !== 1'b1);
    o_req <= 1'b0;
    o_dat <= ~dat;
  endtask : xfer
endmodule : idr_host
`default_nettype wire

/* File: sim/idr_responder_tb_top.sv */
// Self-checking bench for the identify responder
`timescale 1ns/1ps
`default_nettype none
module idr_responder_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req, we, ack, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, geom;
  logic [3:0] opts;
  logic [31:0] exp_q[$];
  logic [15:0] w2[4] = '{16'h37c8, 16'h738c, 16'h8c73, 16'hc837};
  int n_fail = 0;
  int total_checks = 0;
  int seed = 96964;
  always #5 clk = ~clk;
  idr_responder idr_responder_inst (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_WB_CYC(req),
    .I_WB_STB(req), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hf),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_IRQ(irq));
  idr_host idr_host_inst (.i_clk(clk), .i_ack(ack), .o_req(req), .o_we(we), .o_adr(adr),
    .o_dat(wdat));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    idr_host_inst.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    idr_host_inst.xfer(1'b1, a, d);
  endtask : wr
  // Expected identify word from the geometry and options last written
  function automatic logic [15:0] wexp(input int w);
    case (w)
      0: return opts[0] ? 16'h045e : 16'h045a;
      1: return geom[15:0];
      2: return w2[opts[2:1]];
      3: return {8'h00, geom[23:16]};
      6: return 16'h003f;
      47: return {8'h80, geom[31:24]};
      48: return {15'h2000, opts[3]};
      default: return (w inside {[10:19], [23:46]}) ? 16'h2020 : 16'h0000;
    endcase
  endfunction : wexp
  // Each answer is paired with the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk("read data", rdat, exp_q.pop_front());
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h10, 32'h0000_0050);
    rd(8'h04, 32'h0000_0000);
    rd(8'h1c, 32'h1010_3fff);
    rd(8'h3c, 32'h0000_0000);
    wr(8'h18, 32'h0000_0007);
    // Every spin-up code, random geometry, full sector each time
    for (int k = 0; k < 4; k++) begin
      geom = $random(seed);
      opts = {geom[0], k[1:0], geom[1]};
      wr(8'h1c, geom);
      wr(8'h20, {28'h0, opts});
      wr(8'h08, 32'h0000_00a0);
      wr(8'h0c, 32'h0000_00ec);
      #1 chk("irq", {31'h0, irq}, 32'h1);
      rd(8'h10, 32'h0000_0058);
      for (int w = 0; w < 256; w++) rd(8'h00, {16'h0, wexp(w)});
      rd(8'h10, 32'h0000_0050);
      rd(8'h14, 32'h0000_0003);
      wr(8'h14, 32'h0000_0007);
      #1 chk("irq", {31'h0, irq}, 32'h0);
    end
    // Bad code aborts, masking hides it, other device is ignored
    wr(8'h0c, 32'h0000_0090);
    rd(8'h04, 32'h0000_0004);
    rd(8'h10, 32'h0000_0051);
    #1 chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h18, 32'h0000_0000);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h14, 32'h0000_0007);
    wr(8'h08, 32'h0000_00b0);
    wr(8'h0c, 32'h0000_00ec);
    rd(8'h14, 32'h0000_0000);
    close_out();
  end
endmodule : idr_responder_tb_top
`default_nettype wire
